// file: core/lfclk_params.svh
`ifndef LFCLK_PARAMS_SVH
`define LFCLK_PARAMS_SVH

`define LFCLK_XTAL_HZ           32768
`define LFCLK_RC_HZ             32000
`define LFCLK_CORE_HZ           40000000
`define LFCLK_PROC_EN_RST       1'b1
`define LFCLK_PROTECT_RST       1'b0
`define LFCLK_MASK_RST          1'b1
`define LFCLK_DRIVE_RST         2'h0
`define LFCLK_DRIVE_HIZ         2'h2
`define LFCLK_QUAL_EDGES        16
`define LFCLK_LOSS_NS           91000
`define LFCLK_LOSS_CYC          ((`LFCLK_LOSS_NS * (`LFCLK_CORE_HZ / 1000000)) / 1000)
`define LFCLK_RC_HALF_CYC       (`LFCLK_CORE_HZ / (2 * `LFCLK_RC_HZ))

`endif

// file: core/lfclk_pkg.sv
package lfclk_pkg;

  typedef enum logic [1:0]
  {
    PWR_OFF,
    PWR_LOW_OFF,
    PWR_ON
  } pwr_mode_t;

  typedef struct packed
  {
    logic       proc_clk_out_enable;
    logic       rights_protect_mode;
    logic       clock_change_mask;
    logic [1:0] periph_clk_drive_sel;
  } lfclk_cfg_t;

  typedef struct packed
  {
    logic       clock_source_status;
    logic       clock_change_flag;
    logic       clock_change_irq;
  } lfclk_status_t;

endpackage

// file: core/low_freq_clock_source_control.sv
`timescale 1ns/1ps
`include "lfclk_params.svh"

module low_freq_clock_source_control
  import lfclk_pkg::*;
#(
  parameter int LOSS_CYC   = `LFCLK_LOSS_CYC,
  parameter int QUAL_EDGES = `LFCLK_QUAL_EDGES,
  parameter int RC_HALF    = `LFCLK_RC_HALF_CYC
)
(
  input  wire logic          core_clk_i,
  input  wire logic          rst_i,
  input  wire logic          crystal_in_i,
  input  wire logic          seq_drivers_on_i,
  input  wire pwr_mode_t     pwr_mode_i,
  input  wire lfclk_cfg_t    cfg_wr_i,
  input  wire logic          cfg_we_i,
  input  wire logic          flag_clear_i,
  output logic               processor_clock_out_o,
  output logic               processor_clock_oe_n_o,
  output logic               peripheral_clock_out_o,
  output logic               peripheral_clock_oe_n_o,
  output logic [1:0]         periph_drive_o,
  output logic               slow_tick_o,
  output lfclk_cfg_t         cfg_o,
  output lfclk_status_t      status_o
);

  localparam int QW = $clog2(QUAL_EDGES + 1);
  localparam int LW = $clog2(LOSS_CYC + 1);
  localparam int RW = $clog2(RC_HALF + 1);

  ////////////////////////////////////////////////////////////////////////////
  // shared decode

  // last count of an rc half period
  function automatic logic rc_wrap(input logic [RW-1:0] cnt);
    return (cnt == RW'(RC_HALF - 1));
  endfunction

  // protect mode overrides sequencer, enable bit and mode
  function automatic logic proc_drive_on
  (
    input lfclk_cfg_t c,
    input logic       seq_on,
    input pwr_mode_t  mode
  );
    logic drv_on;
    drv_on = 1'b0;
    if (c.rights_protect_mode)
    begin
      drv_on = 1'b1;
    end
    else if (seq_on && c.proc_clk_out_enable)
    begin
      drv_on = (mode != PWR_OFF);
    end
    return drv_on;
  endfunction

  // drive code 10 leaves the pin floating
  function automatic logic periph_drive_on
  (
    input lfclk_cfg_t c,
    input logic       seq_on,
    input pwr_mode_t  mode
  );
    return seq_on && (mode == PWR_ON)
           && (c.periph_clk_drive_sel != `LFCLK_DRIVE_HIZ);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // crystal pin synchroniser and edge detect

  logic xs1;
  logic xs2;
  logic xs3;
  logic xtal_edge;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      xs1 <= 1'b0;
      xs2 <= 1'b0;
      xs3 <= 1'b0;
    end
    else
    begin
      xs1 <= crystal_in_i;
      xs2 <= xs1;
      xs3 <= xs2;
    end
  end

  assign xtal_edge = xs2 ^ xs3;

  ////////////////////////////////////////////////////////////////////////////
  // internal rc oscillator model and source selection

  typedef enum logic [1:0]
  {
    SRC_RC,
    SRC_WAIT_TO_XTAL,
    SRC_XTAL,
    SRC_WAIT_TO_RC
  } src_state_t;

  src_state_t        state;
  src_state_t        next_state;
  logic [RW-1:0]     rc_cnt;
  logic [RW-1:0]     next_rc_cnt;
  logic              rc_clk;
  logic              next_rc_clk;
  logic [QW-1:0]     qual_cnt;
  logic [QW-1:0]     next_qual_cnt;
  logic [LW-1:0]     loss_cnt;
  logic [LW-1:0]     next_loss_cnt;
  logic              sel_xtal;
  logic              next_sel_xtal;
  logic              clk_mux;
  logic              next_clk_mux;
  logic              xtal_ok;
  logic              rc_low_phase;

  assign xtal_ok      = (qual_cnt == QW'(QUAL_EDGES));
  assign rc_low_phase = ~rc_clk && rc_wrap(rc_cnt);

  always_comb
  begin
    next_state    = state;
    next_sel_xtal = sel_xtal;
    next_rc_cnt   = rc_cnt + RW'(1);
    next_rc_clk   = rc_clk;
    if (rc_wrap(rc_cnt))
    begin
      next_rc_cnt = '0;
      next_rc_clk = ~rc_clk;
    end
    next_loss_cnt = xtal_edge ? '0 : loss_cnt;
    if (!xtal_edge && loss_cnt != LW'(LOSS_CYC))
      next_loss_cnt = loss_cnt + LW'(1);
    next_qual_cnt = qual_cnt;
    if (loss_cnt == LW'(LOSS_CYC))
      next_qual_cnt = '0;
    else if (xtal_edge && !xtal_ok)
      next_qual_cnt = qual_cnt + QW'(1);
    case (state)
      SRC_RC:
        if (xtal_ok)
          next_state = SRC_WAIT_TO_XTAL;
      SRC_WAIT_TO_XTAL:
        if (!xtal_ok)
          next_state = SRC_RC;
        else if (rc_low_phase && !xs2)
        begin
          next_state    = SRC_XTAL;
          next_sel_xtal = 1'b1;
        end
      SRC_XTAL:
        if (!xtal_ok)
          next_state = SRC_WAIT_TO_RC;
      SRC_WAIT_TO_RC:
        if (rc_low_phase)
        begin
          next_state    = SRC_RC;
          next_sel_xtal = 1'b0;
        end
      default:
        next_state = SRC_RC;
    endcase
    // output held low through the switchover window
    if (state == SRC_WAIT_TO_XTAL || state == SRC_WAIT_TO_RC)
      next_clk_mux = 1'b0;
    else
      next_clk_mux = sel_xtal ? xs2 : rc_clk;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state    <= SRC_RC;
      sel_xtal <= 1'b0;
      rc_cnt   <= '0;
      rc_clk   <= 1'b0;
      qual_cnt <= '0;
      loss_cnt <= '0;
      clk_mux  <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      sel_xtal <= next_sel_xtal;
      rc_cnt   <= next_rc_cnt;
      rc_clk   <= next_rc_clk;
      qual_cnt <= next_qual_cnt;
      loss_cnt <= next_loss_cnt;
      clk_mux  <= next_clk_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // derived slow tick: one pulse per rising edge of selected clock

  logic mux_q;
  logic next_tick;

  always_comb
  begin
    next_tick = clk_mux & ~mux_q;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      mux_q       <= 1'b0;
      slow_tick_o <= 1'b0;
    end
    else
    begin
      mux_q       <= clk_mux;
      slow_tick_o <= next_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration, status flag and output drivers

  lfclk_cfg_t     next_cfg;
  logic           next_flag;
  logic           src_change;
  logic           proc_drv;
  logic           periph_drv;

  assign src_change = (next_sel_xtal != sel_xtal);

  always_comb
  begin
    next_cfg = cfg_we_i ? cfg_wr_i : cfg_o;
    // set beats a simultaneous clear
    next_flag = status_o.clock_change_flag;
    if (flag_clear_i)
      next_flag = 1'b0;
    if (src_change)
      next_flag = 1'b1;
    proc_drv   = proc_drive_on(cfg_o, seq_drivers_on_i, pwr_mode_i);
    periph_drv = periph_drive_on(cfg_o, seq_drivers_on_i, pwr_mode_i);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cfg_o.proc_clk_out_enable  <= `LFCLK_PROC_EN_RST;
      cfg_o.rights_protect_mode  <= `LFCLK_PROTECT_RST;
      cfg_o.clock_change_mask    <= `LFCLK_MASK_RST;
      cfg_o.periph_clk_drive_sel <= `LFCLK_DRIVE_RST;
      status_o                   <= '0;
      processor_clock_out_o      <= 1'b0;
      processor_clock_oe_n_o     <= 1'b1;
      peripheral_clock_out_o     <= 1'b0;
      peripheral_clock_oe_n_o    <= 1'b1;
      periph_drive_o             <= `LFCLK_DRIVE_RST;
    end
    else
    begin
      cfg_o                        <= next_cfg;
      status_o.clock_source_status <= next_sel_xtal;
      status_o.clock_change_flag   <= next_flag;
      status_o.clock_change_irq    <= next_flag & ~next_cfg.clock_change_mask;
      processor_clock_out_o        <= clk_mux & proc_drv;
      processor_clock_oe_n_o       <= ~proc_drv;
      peripheral_clock_out_o       <= clk_mux & periph_drv;
      peripheral_clock_oe_n_o      <= ~periph_drv;
      periph_drive_o               <= cfg_o.periph_clk_drive_sel;
    end
  end

endmodule

// file: verification/lfclk_properties.sv
`timescale 1ns/1ps
module lfclk_properties
  import lfclk_pkg::*;
(
  input wire logic          core_clk_i,
  input wire logic          rst_i,
  input wire pwr_mode_t     pwr_mode_i,
  input wire logic          processor_clock_out_o,
  input wire logic          processor_clock_oe_n_o,
  input wire logic          peripheral_clock_oe_n_o,
  input wire lfclk_cfg_t    cfg_o,
  input wire lfclk_status_t status_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  chk_irq_flag: assert property (status_o[0] |-> status_o[1])
    else $error("irq without flag");
  chk_flag_change: assert property ($changed(status_o[2]) |-> status_o[1])
    else $error("source change without flag");
  chk_hiz_drive: assert property (cfg_o[1:0] == 2'h2 |=> peripheral_clock_oe_n_o)
    else $error("hi-z code drives");
  chk_periph_mode: assert property (pwr_mode_i != PWR_ON |=> peripheral_clock_oe_n_o)
    else $error("peripheral on outside on mode");
  chk_protect_on: assert property (cfg_o[3] |=> !processor_clock_oe_n_o)
    else $error("protect mode driver off");
  chk_off_mode: assert property (!cfg_o[3] && pwr_mode_i == PWR_OFF |=> processor_clock_oe_n_o)
    else $error("driver on in off");
  chk_proc_en: assert property (!cfg_o[4] && !cfg_o[3] |=> processor_clock_oe_n_o)
    else $error("enable bit ignored");
  chk_clk_gated: assert property (processor_clock_oe_n_o |-> !processor_clock_out_o)
    else $error("clock while driver off");
endmodule
bind low_freq_clock_source_control lfclk_properties chk_u (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .pwr_mode_i(pwr_mode_i), .processor_clock_out_o(processor_clock_out_o),
  .processor_clock_oe_n_o(processor_clock_oe_n_o),
  .peripheral_clock_oe_n_o(peripheral_clock_oe_n_o), .cfg_o(cfg_o), .status_o(status_o));

// file: verification/xtal_model.sv
`timescale 1ns/1ps
module xtal_model
(
  input  wire logic run_i,
  output logic      xtal_o
);
  initial xtal_o = 1'b0;
  // stopped crystal rests low
  always #47 xtal_o = run_i ? ~xtal_o : 1'b0;
endmodule

// file: verification/low_freq_clock_source_control_tb.sv
`timescale 1ns/1ps
module low_freq_clock_source_control_tb
  import lfclk_pkg::*;
;
  logic clk = 0, rst = 1, xrun = 0, seq = 0, we = 0, clr = 0, xtal;
  logic pco, poe, fco, foe, tick;
  logic [1:0] drv;
  pwr_mode_t mode = PWR_OFF;
  lfclk_cfg_t wr = '0, cfg;
  lfclk_status_t st;
  int err_count = 0, checked = 0, n;
  logic [31:0] lfsr = 32'h8477;
  initial forever #12.5 clk = ~clk;
  xtal_model xm_u (.run_i(xrun), .xtal_o(xtal));
  low_freq_clock_source_control #(.LOSS_CYC(8), .QUAL_EDGES(4), .RC_HALF(5)) dut_u (
    .core_clk_i(clk), .rst_i(rst), .crystal_in_i(xtal), .seq_drivers_on_i(seq),
    .pwr_mode_i(mode), .cfg_wr_i(wr), .cfg_we_i(we), .flag_clear_i(clr),
    .processor_clock_out_o(pco), .processor_clock_oe_n_o(poe),
    .peripheral_clock_out_o(fco), .peripheral_clock_oe_n_o(foe), .periph_drive_o(drv),
    .slow_tick_o(tick), .cfg_o(cfg), .status_o(st));
  function automatic logic [31:0] nxt(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [2:0] exp_out(lfclk_cfg_t c, pwr_mode_t m, logic s);
    return {!c[3] && !(s && c[4] && m != PWR_OFF), !(s && m == PWR_ON) || c[1:0] == 2'h2,
      1'b0};
  endfunction
  task automatic chk(string nm, logic [4:0] e, logic [4:0] g);
    checked++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic wait_src(logic v);
    n = 0;
    while (st[2] !== v && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    #1;
  endtask
  task automatic end_sim;
    if (err_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #75000;
    err_count++;
    end_sim;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1;
    chk("cfg", 5'h14, cfg);
    chk("status", 0, st);
    n = 0;
    repeat (200) @(negedge clk) n += tick;
    chk("ticks", 1, n >= 19 && n <= 21);
    chk("src", 0, st[2]);
    @(posedge clk);
    {seq, xrun, mode} <= {2'b11, PWR_ON};
    wait_src(1);
    chk("src", 5'h6, st);
    @(posedge clk);
    {wr, we} <= {5'h10, 1'b1};
    @(posedge clk);
    we <= 0;
    @(posedge clk);
    #1;
    chk("irq", 3, st[1:0]);
    clr <= 1;
    @(posedge clk);
    clr <= 0;
    @(posedge clk);
    #1;
    chk("clear", 4, st);
    xrun <= 0;
    wait_src(0);
    chk("fall", 1, st[2:1]);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      lfsr = nxt(lfsr);
      {wr, we, seq} <= {lfsr[4:2], i[1:0], 1'b1, lfsr[7]};
      mode <= pwr_mode_t'(lfsr[6:5] % 3);
      @(posedge clk);
      we <= 0;
      @(posedge clk);
      #1;
      chk("cfg", wr, cfg);
      chk("drv", wr[1:0], drv);
      chk("oe", exp_out(wr, mode, seq), {poe, foe, 1'b0});
      chk("pgate", 0, pco & poe);
      chk("fgate", 0, fco & foe);
    end
    @(posedge clk);
    rst <= 1;
    repeat (3) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    #1;
    chk("cfg", 5'h14, cfg);
    chk("status", 0, st);
    chk("oe", 5'h6, {poe, foe, 1'b0});
    end_sim;
  end
endmodule
